// file: hw/exc_unit.sv
// Purpose: Address and translation fault recording unit
// Assumes: Pipeline gives one reference per request pulse
// Notes:   Registers reached over a plain strobe port, read data one
//          cycle after the read strobe
`timescale 1ns/100ps
`default_nettype none
module exc_unit #(
  parameter logic [4:0]            MODIFIED_CODE         = 5'h01,
  parameter logic [4:0]            XLATE_MISS_LOAD_CODE  = 5'h02,
  parameter logic [4:0]            XLATE_MISS_STORE_CODE = 5'h03,
  parameter logic [4:0]            ADDR_FAULT_LOAD_CODE  = 5'h04,
  parameter logic [4:0]            ADDR_FAULT_STORE_CODE = 5'h05,
  parameter logic [`EXC_IDX_W-1:0] RAND_TOP              = 6'h2f,
  parameter logic [`EXC_IDX_W-1:0] RAND_LOW              = 6'h00
) (
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_rst,
  input  wire logic                        i_req,
  input  wire exc_pkg::access_type         i_access,
  input  wire exc_pkg::size_type           i_size,
  input  wire logic                        i_unaligned_ok,
  input  wire exc_pkg::mode_type           i_mode,
  input  wire logic                 [63:0] i_va,
  input  wire logic                 [63:0] i_pc,
  input  wire logic                 [63:0] i_branch_pc,
  input  wire logic                        i_in_delay,
  input  wire logic                        i_tlb_hit,
  input  wire logic                        i_tlb_valid,
  input  wire logic                        i_tlb_dirty,
  input  wire logic     [`EXC_IDX_W-1:0]   i_tlb_index,
  input  wire logic                        i_probe,
  input  wire logic                  [7:0] i_addr,
  input  wire logic                 [63:0] i_wr_data,
  input  wire logic                        i_wr_stb,
  input  wire logic                        i_rd_stb,
  output logic                             o_exc_taken,
  output logic                      [63:0] o_exc_vector,
  output logic                       [7:0] o_as_tag,
  output logic                             o_exc_level,
  output logic                      [63:0] o_rd_data
);
  exc_pkg::state_type st_ff, nxt_st;
  logic               fault;

  exc_if xif ();

  fault_detect u_detect (
    .i_va           (i_va),
    .i_access       (i_access),
    .i_size         (i_size),
    .i_unaligned_ok (i_unaligned_ok),
    .i_mode         (i_mode),
    .i_tlb_hit      (i_tlb_hit),
    .i_tlb_valid    (i_tlb_valid),
    .i_tlb_dirty    (i_tlb_dirty),
    .xif            (xif)
  );

  vector_select u_vector (
    .xif (xif)
  );

  assign xif.exc_level   = st_ff.exc_level;
  assign xif.boot_vec    = st_ff.boot_vec;
  assign xif.user_wide   = st_ff.user_wide;
  assign xif.super_wide  = st_ff.super_wide;
  assign xif.kernel_wide = st_ff.kernel_wide;

  // Address faults cannot be masked: no enable gates this
  assign fault = i_req && xif.kind != exc_pkg::F_NONE;

  always_comb
  begin
    nxt_st         = st_ff;
    nxt_st.taken   = 1'b0;
    nxt_st.rd_data = '0;

    // Free-running slot pick keeps a legal entry at any fault
    if (st_ff.rand_idx == RAND_LOW)
      nxt_st.rand_idx = RAND_TOP;
    else
      nxt_st.rand_idx = st_ff.rand_idx - 1'b1;

    if (i_wr_stb)
      case (i_addr)
        `EXC_OFF_INDEX:
          nxt_st.index = {i_wr_data[`EXC_IDX_MISS],
                          {(31-`EXC_IDX_W){1'b0}},
                          i_wr_data[`EXC_IDX_W-1:0]};
        `EXC_OFF_PT_PTR:
          nxt_st.pt_ptr[`EXC_PT_BASE] = i_wr_data[`EXC_PT_BASE];
        `EXC_OFF_WIDE_PT:
          nxt_st.wide_pt[`EXC_WPT_BASE] = i_wr_data[`EXC_WPT_BASE];
        `EXC_OFF_XLATE_HI:
        begin
          nxt_st.xlate_hi = '0;
          nxt_st.xlate_hi[`EXC_HI_REGION] = i_wr_data[`EXC_HI_REGION];
          nxt_st.xlate_hi[`EXC_HI_VPN]    = i_wr_data[`EXC_HI_VPN];
          nxt_st.xlate_hi[`EXC_HI_TAG]    = i_wr_data[`EXC_HI_TAG];
        end
        `EXC_OFF_STATUS:
        begin
          nxt_st.exc_level   = i_wr_data[`EXC_ST_LEVEL];
          nxt_st.boot_vec    = i_wr_data[`EXC_ST_BOOT];
          nxt_st.user_wide   = i_wr_data[`EXC_ST_USER_W];
          nxt_st.super_wide  = i_wr_data[`EXC_ST_SUPER_W];
          nxt_st.kernel_wide = i_wr_data[`EXC_ST_KERNEL_W];
        end
        `EXC_OFF_RET_ADDR:
          nxt_st.ret_addr = i_wr_data;
        default:
          nxt_st.index = nxt_st.index;
      endcase

    if (i_probe)
    begin
      nxt_st.index = '0;
      if (i_tlb_hit)
        nxt_st.index[`EXC_IDX_W-1:0] = i_tlb_index;
      else
        nxt_st.index[`EXC_IDX_MISS] = 1'b1;
    end

    // Hardware fault capture overrides a same-cycle software write
    if (fault)
    begin
      nxt_st.taken      = 1'b1;
      nxt_st.vector     = xif.vector;
      nxt_st.exc_level  = 1'b1;
      nxt_st.delay_flag = i_in_delay;
      nxt_st.fault_va   = i_va;
      // A fault already inside a handler keeps the first return point
      if (!st_ff.exc_level)
        nxt_st.ret_addr = i_in_delay ? i_branch_pc : i_pc;
      case (xif.kind)
        exc_pkg::F_ADDR:
          nxt_st.code = xif.store ? ADDR_FAULT_STORE_CODE
                                  : ADDR_FAULT_LOAD_CODE;
        exc_pkg::F_REFILL, exc_pkg::F_INVALID:
          nxt_st.code = xif.store ? XLATE_MISS_STORE_CODE
                                  : XLATE_MISS_LOAD_CODE;
        exc_pkg::F_MODIFIED:
          nxt_st.code = MODIFIED_CODE;
        default:
          nxt_st.code = st_ff.code;
      endcase
      if (xif.kind != exc_pkg::F_ADDR)
      begin
        nxt_st.pt_ptr[`EXC_PT_VPN]       = i_va[`EXC_VA_VPN32];
        nxt_st.wide_pt[`EXC_WPT_REGION]  = i_va[`EXC_HI_REGION];
        nxt_st.wide_pt[`EXC_WPT_VPN]     = i_va[`EXC_HI_VPN];
        nxt_st.xlate_hi[`EXC_HI_REGION]  = i_va[`EXC_HI_REGION];
        nxt_st.xlate_hi[`EXC_HI_VPN]     = i_va[`EXC_HI_VPN];
        // Tag stays the one in force when the fault hit
        nxt_st.xlate_hi[`EXC_HI_TAG]     = st_ff.xlate_hi[`EXC_HI_TAG];
      end
    end

    if (i_rd_stb)
      case (i_addr)
        `EXC_OFF_INDEX:    nxt_st.rd_data[31:0] = st_ff.index;
        `EXC_OFF_RANDOM:
          nxt_st.rd_data[`EXC_IDX_W-1:0] = st_ff.rand_idx;
        `EXC_OFF_PT_PTR:   nxt_st.rd_data = st_ff.pt_ptr;
        `EXC_OFF_FAULT_VA: nxt_st.rd_data = st_ff.fault_va;
        `EXC_OFF_XLATE_HI: nxt_st.rd_data = st_ff.xlate_hi;
        `EXC_OFF_WIDE_PT:  nxt_st.rd_data = st_ff.wide_pt;
        `EXC_OFF_RET_ADDR: nxt_st.rd_data = st_ff.ret_addr;
        `EXC_OFF_STATUS:
        begin
          nxt_st.rd_data[`EXC_ST_LEVEL]    = st_ff.exc_level;
          nxt_st.rd_data[`EXC_ST_BOOT]     = st_ff.boot_vec;
          nxt_st.rd_data[`EXC_ST_USER_W]   = st_ff.user_wide;
          nxt_st.rd_data[`EXC_ST_SUPER_W]  = st_ff.super_wide;
          nxt_st.rd_data[`EXC_ST_KERNEL_W] = st_ff.kernel_wide;
        end
        `EXC_OFF_CAUSE:
        begin
          nxt_st.rd_data[`EXC_CA_DELAY] = st_ff.delay_flag;
          nxt_st.rd_data[`EXC_CA_CODE]  = st_ff.code;
        end
        default:
          nxt_st.rd_data = '0;
      endcase
  end

  // Boot vector bit comes up set, slot pick at RAND_TOP, the rest of state clear
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_ff          <= '0;
      st_ff.boot_vec <= 1'b1;
      st_ff.rand_idx <= RAND_TOP;
    end
    else
      st_ff <= nxt_st;
  end

  assign o_exc_taken  = st_ff.taken;
  assign o_exc_vector = st_ff.vector;
  assign o_as_tag     = st_ff.xlate_hi[`EXC_HI_TAG];
  assign o_exc_level  = st_ff.exc_level;
  assign o_rd_data    = st_ff.rd_data;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  // Independent copies of the checks, so a slip in the detector shows
  logic        chk_data;
  logic        chk_compat;
  logic        chk_mapped;
  logic [63:0] chk_base;

  assign chk_data   = i_req && i_access != exc_pkg::ACC_FETCH;
  assign chk_compat = i_va[63:32] == `EXC_COMPAT_HI;
  assign chk_mapped = i_va[63:62] != `EXC_SEG_PHYS &&
                      !(chk_compat && i_va[31:30] == `EXC_CSEG_UNMAP);
  assign chk_base   = st_ff.boot_vec ? `EXC_BASE_BOOT : `EXC_BASE_NORM;

  sequence s_addr_code;
    o_exc_taken && (st_ff.code == ADDR_FAULT_LOAD_CODE ||
                    st_ff.code == ADDR_FAULT_STORE_CODE);
  endsequence

  sequence s_common_entry(logic [63:0] base);
    o_exc_taken && o_exc_vector == base + `EXC_VEC_COMMON;
  endsequence

  sequence s_refill_req;
    i_req && xif.kind == exc_pkg::F_REFILL;
  endsequence

  a_dword_align: assert property (
    chk_data && i_size == exc_pkg::SZ_DWORD && |i_va[2:0] &&
    !i_unaligned_ok |=> s_addr_code)
    else $error("misaligned doubleword not faulted");

  a_word_align: assert property (
    i_req && i_access == exc_pkg::ACC_FETCH && |i_va[1:0]
    |=> s_addr_code)
    else $error("misaligned fetch not faulted");

  a_half_align: assert property (
    chk_data && i_size == exc_pkg::SZ_HALF && i_va[0] |=> s_addr_code)
    else $error("misaligned halfword not faulted");

  a_kernel_guard: assert property (
    i_req && i_mode != exc_pkg::MODE_KERNEL && i_va[63:62] == 2'b11 &&
    !chk_compat |=> s_addr_code)
    else $error("kernel space reached from lower mode");

  a_super_guard: assert property (
    i_req && i_mode == exc_pkg::MODE_USER &&
    i_va[63:62] == `EXC_SEG_SUPER |=> s_addr_code)
    else $error("supervisor space reached from user mode");

  a_addr_entry: assert property (
    i_req && xif.kind == exc_pkg::F_ADDR
    |=> s_common_entry($past(chk_base)) and
        (st_ff.code == ($past(xif.store) ? ADDR_FAULT_STORE_CODE
                                         : ADDR_FAULT_LOAD_CODE)))
    else $error("address fault entry or code wrong");

  a_fault_addr: assert property (
    fault |=> st_ff.fault_va == $past(i_va) && st_ff.exc_level)
    else $error("faulting address not captured");

  a_return_point: assert property (
    fault && !st_ff.exc_level
    |=> st_ff.ret_addr == ($past(i_in_delay) ? $past(i_branch_pc)
                                             : $past(i_pc)) &&
        st_ff.delay_flag == $past(i_in_delay))
    else $error("return point or delay flag wrong");

  a_refill_raise: assert property (
    i_req && chk_mapped && !i_tlb_hit && xif.kind != exc_pkg::F_ADDR
    |=> o_exc_taken)
    else $error("unmatched mapped reference not faulted");

  a_refill_entry: assert property (
    (s_refill_req and !st_ff.exc_level)
    |=> o_exc_taken && (o_exc_vector == $past(chk_base) +
        ($past(xif.wide) ? `EXC_VEC_WIDE : `EXC_VEC_NARROW)))
    else $error("refill entry not dedicated");

  a_nested_refill: assert property (
    (s_refill_req and st_ff.exc_level) |=> s_common_entry($past(chk_base)))
    else $error("nested refill left common entry");

  a_tag_kept: assert property (
    fault && xif.kind != exc_pkg::F_ADDR && !i_wr_stb
    |=> st_ff.xlate_hi[`EXC_HI_TAG] == $past(st_ff.xlate_hi[`EXC_HI_TAG]) &&
        st_ff.xlate_hi[`EXC_HI_VPN] == $past(i_va[`EXC_HI_VPN]))
    else $error("translation fault lost tag or page");

  a_miss_code: assert property (
    i_req && (xif.kind == exc_pkg::F_REFILL ||
              xif.kind == exc_pkg::F_INVALID)
    |=> st_ff.code == ($past(xif.store) ? XLATE_MISS_STORE_CODE
                                        : XLATE_MISS_LOAD_CODE))
    else $error("miss code wrong");

  a_slot_range: assert property (
    st_ff.rand_idx >= RAND_LOW && st_ff.rand_idx <= RAND_TOP)
    else $error("replacement slot out of range");

  a_modified_code: assert property (
    chk_data && i_access == exc_pkg::ACC_STORE && chk_mapped &&
    i_tlb_hit && i_tlb_valid && !i_tlb_dirty &&
    xif.kind != exc_pkg::F_ADDR
    |=> st_ff.code == MODIFIED_CODE ##0 s_common_entry($past(chk_base)))
    else $error("clean-page store not flagged");

  a_probe_index: assert property (
    i_probe && i_tlb_hit && !i_wr_stb
    |=> st_ff.index[`EXC_IDX_W-1:0] == $past(i_tlb_index) &&
        !st_ff.index[`EXC_IDX_MISS])
    else $error("probe position not recorded");

  a_read_once: assert property (
    !i_rd_stb |=> o_rd_data == 64'h0000_0000_0000_0000)
    else $error("read data outside its cycle");
endmodule
`default_nettype wire

// file: hw/exc_cfg.svh
// Purpose: Constants of the address and translation fault unit
// Assumes: 64-bit virtual addresses, 25 MHz pipeline clock
// Notes:   Register offsets are byte addresses on the plain port
//
// Summary of operation
// - Doubleword access off an eight-byte boundary faults, unless unaligned op
// - Word load or store off a four-byte boundary faults, unless unaligned op; misaligned fetch always faults
// - Halfword access off a two-byte boundary faults
// - User or supervisor code touching kernel space faults
// - User code touching supervisor space faults; address faults never masked
// - Address fault uses common vector, load-side or store-side code
// - Address fault captures the bad virtual address
// - Return address is faulting instruction, or branch with delay flag set; left as is when exception level already set
// - Mapped reference with no matching entry raises refill
// - Refill picks narrow or wide vector from per-mode wide-address bits
// - Refill vectors only with exception level clear, else common vector
// - Refill loads bad address into fault, pointer and high registers
// - Translation faults keep the current address space tag in high register
// - Refill and invalid write load/fetch or store miss code
// - Replacement slot register always holds a usable entry position
// - Match on entry with valid bit clear raises invalid, common vector
// - Store hitting valid clean entry raises modified, write-protect code
// - Probe writes matching entry position into index register
// - Offsets 0x000 narrow refill, 0x080 wide refill, 0x180 others
// - Base 0xffffffff80000000 normally, 0xffffffffbfc00200 with boot bit
// - Address faults outrank refill, then invalid, then modified
`ifndef EXC_CFG_SVH
`define EXC_CFG_SVH
`define EXC_IDX_W        6
`define EXC_OFF_INDEX    8'h00
`define EXC_OFF_RANDOM   8'h08
`define EXC_OFF_PT_PTR   8'h10
`define EXC_OFF_FAULT_VA 8'h18
`define EXC_OFF_XLATE_HI 8'h20
`define EXC_OFF_STATUS   8'h28
`define EXC_OFF_CAUSE    8'h30
`define EXC_OFF_RET_ADDR 8'h38
`define EXC_OFF_WIDE_PT  8'h40
`define EXC_BASE_NORM    64'hffff_ffff_8000_0000
`define EXC_BASE_BOOT    64'hffff_ffff_bfc0_0200
`define EXC_VEC_NARROW   64'h0000_0000_0000_0000
`define EXC_VEC_WIDE     64'h0000_0000_0000_0080
`define EXC_VEC_COMMON   64'h0000_0000_0000_0180
`define EXC_ST_LEVEL     1
`define EXC_ST_USER_W    5
`define EXC_ST_SUPER_W   6
`define EXC_ST_KERNEL_W  7
`define EXC_ST_BOOT      22
`define EXC_CA_DELAY     31
`define EXC_CA_CODE      6:2
`define EXC_IDX_MISS     31
`define EXC_HI_TAG       7:0
`define EXC_HI_VPN       39:13
`define EXC_HI_REGION    63:62
`define EXC_PT_BASE      63:23
`define EXC_PT_VPN       22:4
`define EXC_VA_VPN32     31:13
`define EXC_WPT_BASE     63:33
`define EXC_WPT_REGION   32:31
`define EXC_WPT_VPN      30:4
`define EXC_VA_SEG       63:62
`define EXC_SEG_USER     2'b00
`define EXC_SEG_SUPER    2'b01
`define EXC_SEG_PHYS     2'b10
`define EXC_COMPAT_HI    32'hffff_ffff
`define EXC_CSEG_SUPER   3'b110
`define EXC_CSEG_UNMAP   2'b10
`endif

// file: hw/exc_pkg.sv
// Purpose: Types shared by the fault unit modules
// Assumes: exc_cfg.svh supplies widths and field positions
// Notes:   The whole register state lives in one packed struct
`include "exc_cfg.svh"
package exc_pkg;
  typedef enum logic [1:0] {ACC_FETCH, ACC_LOAD, ACC_STORE} access_type;
  typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD, SZ_DWORD} size_type;
  typedef enum logic [1:0] {MODE_USER, MODE_SUPER, MODE_KERNEL} mode_type;
  typedef enum logic [2:0] {F_NONE, F_ADDR, F_REFILL, F_INVALID, F_MODIFIED}
    fault_kind_type;
  typedef struct packed {
    logic                  taken;
    logic [63:0]           vector;
    logic [63:0]           rd_data;
    logic [63:0]           ret_addr;
    logic [63:0]           fault_va;
    logic [63:0]           pt_ptr;
    logic [63:0]           wide_pt;
    logic [63:0]           xlate_hi;
    logic [31:0]           index;
    logic [`EXC_IDX_W-1:0] rand_idx;
    logic                  exc_level;
    logic                  boot_vec;
    logic                  user_wide;
    logic                  super_wide;
    logic                  kernel_wide;
    logic                  delay_flag;
    logic [4:0]            code;
  } state_type;
endpackage

// file: hw/exc_if.sv
// Purpose: Carrier between fault detection, vector choice and core
// Assumes: One fault decision per cycle
// Notes:   Core drives the status bits, leaves read them
`timescale 1ns/100ps
`default_nettype none
interface exc_if;
  exc_pkg::fault_kind_type kind;
  logic                    store;
  logic                    wide;
  logic                    exc_level;
  logic                    boot_vec;
  logic                    user_wide;
  logic                    super_wide;
  logic                    kernel_wide;
  logic [63:0]             vector;
  modport det  (output kind, store, wide,
                input user_wide, super_wide, kernel_wide);
  modport vec  (input kind, wide, exc_level, boot_vec, output vector);
  modport core (input kind, store, vector,
                output exc_level, boot_vec, user_wide, super_wide,
                kernel_wide);
endinterface
`default_nettype wire

// file: hw/fault_detect.sv
// Purpose: Classify one reference into its highest fault
// Assumes: TLB lookup result arrives in the same cycle as the address
// Notes:   Fetches are always checked as word accesses
`timescale 1ns/100ps
`default_nettype none
module fault_detect (
  input  wire logic                 [63:0] i_va,
  input  wire exc_pkg::access_type         i_access,
  input  wire exc_pkg::size_type           i_size,
  input  wire logic                        i_unaligned_ok,
  input  wire exc_pkg::mode_type           i_mode,
  input  wire logic                        i_tlb_hit,
  input  wire logic                        i_tlb_valid,
  input  wire logic                        i_tlb_dirty,
  exc_if.det                               xif
);
  logic compat, seg_user, seg_super, seg_kern, unmapped;
  logic misalign, priv, store;

  assign compat    = i_va[63:32] == `EXC_COMPAT_HI;
  assign seg_user  = i_va[`EXC_VA_SEG] == `EXC_SEG_USER;
  assign seg_super = (i_va[`EXC_VA_SEG] == `EXC_SEG_SUPER) ||
                     (compat && i_va[31:29] == `EXC_CSEG_SUPER);
  assign seg_kern  = !seg_user && !seg_super;
  assign unmapped  = (i_va[`EXC_VA_SEG] == `EXC_SEG_PHYS) ||
                     (compat && i_va[31:30] == `EXC_CSEG_UNMAP);
  assign store     = i_access == exc_pkg::ACC_STORE;

  always_comb
  begin
    misalign = 1'b0;
    if (i_access == exc_pkg::ACC_FETCH)
      misalign = |i_va[1:0];
    else
      case (i_size)
        exc_pkg::SZ_HALF:  misalign = i_va[0];
        exc_pkg::SZ_WORD:  misalign = |i_va[1:0] && !i_unaligned_ok;
        exc_pkg::SZ_DWORD: misalign = |i_va[2:0] && !i_unaligned_ok;
        default:           misalign = 1'b0;
      endcase
  end

  assign priv = (i_mode != exc_pkg::MODE_KERNEL && seg_kern) ||
                (i_mode == exc_pkg::MODE_USER && seg_super);

  // Region owner picks which wide-address bit applies
  assign xif.wide  = seg_user  ? xif.user_wide :
                     seg_super ? xif.super_wide : xif.kernel_wide;
  assign xif.store = store;

  always_comb
  begin
    if (misalign || priv)
      xif.kind = exc_pkg::F_ADDR;
    else if (!unmapped && !i_tlb_hit)
      xif.kind = exc_pkg::F_REFILL;
    else if (!unmapped && !i_tlb_valid)
      xif.kind = exc_pkg::F_INVALID;
    else if (!unmapped && store && !i_tlb_dirty)
      xif.kind = exc_pkg::F_MODIFIED;
    else
      xif.kind = exc_pkg::F_NONE;
  end
endmodule
`default_nettype wire

// file: hw/vector_select.sv
// Purpose: Form the exception entry address from base and offset
// Assumes: Kind is valid only while a request is presented
// Notes:   Pure logic; the core registers the result
`timescale 1ns/100ps
`default_nettype none
module vector_select (
  exc_if.vec xif
);
  logic [63:0] base, offset;

  assign base = xif.boot_vec ? `EXC_BASE_BOOT : `EXC_BASE_NORM;

  // Nested refill inside the handler must not reenter the refill entry
  assign offset = (xif.kind == exc_pkg::F_REFILL && !xif.exc_level) ?
                  (xif.wide ? `EXC_VEC_WIDE : `EXC_VEC_NARROW) :
                  `EXC_VEC_COMMON;
  assign xif.vector = base + offset;
endmodule
`default_nettype wire

// file: verification/tlb_model.sv
// Purpose: Lookup model beside the fault unit
// Assumes: Lookup answers in the same cycle as the address
// Notes:   Page bits 14:13 pick the hit kind
`timescale 1ns/100ps
`default_nettype none
module tlb_model (
  input  wire logic [63:0] i_va,
  output logic             o_hit,
  output logic             o_valid,
  output logic             o_dirty,
  output logic [5:0]       o_index
);
  // 0 dirty, 1 clean, 2 invalid, 3 no entry
  assign o_hit   = i_va[14:13] != 2'h3;
  assign o_valid = !i_va[14];
  assign o_dirty = i_va[14:13] == 2'h0;
  assign o_index = i_va[18:13];
endmodule
`default_nettype wire

// file: verification/exc_unit_tb.sv
// Purpose: Self-checking bench of the fault unit
// Assumes: Default exception codes of the unit
// Notes:   Fault kind is chosen by address through the model
`timescale 1ns/100ps
`default_nettype none
`include "exc_cfg.svh"
module exc_unit_tb;
  localparam logic [63:0] BPC = 64'h0ff0;
  localparam logic [63:0] NB = `EXC_BASE_NORM;
  localparam logic [63:0] CV = NB + `EXC_VEC_COMMON;
  logic clk = 1'b0, rst = 1'b1, req = 1'b0, dl = 1'b0;
  logic prb = 1'b0, wr = 1'b0, rd = 1'b0, uok = 1'b0;
  logic hit, vld, drt, tk, lvl;
  logic [5:0] idx;
  logic [7:0] adr = 8'h0, tag;
  logic [63:0] va = 64'h0, pc = 64'h0, wd = 64'h0, rdd, vec;
  exc_pkg::access_type acc = exc_pkg::ACC_LOAD;
  exc_pkg::size_type sz = exc_pkg::SZ_WORD;
  exc_pkg::mode_type md = exc_pkg::MODE_KERNEL;
  int fails = 0, check_count = 0;
  always #20 clk = ~clk;
  tlb_model tlb_model_i (.i_va(va), .o_hit(hit), .o_valid(vld),
    .o_dirty(drt), .o_index(idx));
  exc_unit exc_unit_i (.i_clk_sys(clk), .i_rst(rst), .i_req(req),
    .i_access(acc), .i_size(sz), .i_unaligned_ok(uok), .i_mode(md),
    .i_va(va), .i_pc(pc), .i_branch_pc(BPC), .i_in_delay(dl),
    .i_tlb_hit(hit), .i_tlb_valid(vld), .i_tlb_dirty(drt),
    .i_tlb_index(idx), .i_probe(prb), .i_addr(adr), .i_wr_data(wd),
    .i_wr_stb(wr), .i_rd_stb(rd), .o_exc_taken(tk), .o_exc_vector(vec),
    .o_as_tag(tag), .o_exc_level(lvl), .o_rd_data(rdd));
  task automatic chk(input string n, input logic [63:0] e, g);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rreg(input logic [7:0] a, input logic [63:0] e);
    @(posedge clk);
    rd <= 1'b1;
    adr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("read", e, rdd);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [63:0] d);
    @(posedge clk);
    wr <= 1'b1;
    adr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // One reference; pc is va plus 0x100 so the return value is known
  task automatic go(input exc_pkg::access_type a, exc_pkg::size_type s,
    exc_pkg::mode_type m, logic [63:0] v, logic d, t, logic [63:0] ev,
    logic [4:0] c);
    @(posedge clk);
    req <= 1'b1;
    acc <= a;
    sz <= s;
    md <= m;
    va <= v;
    dl <= d;
    pc <= v + 64'h100;
    @(posedge clk);
    req <= 1'b0;
    #1 chk("taken", {63'h0, t}, {63'h0, tk});
    if (t)
    begin
      chk("vector", ev, vec);
      chk("level", 64'h1, {63'h0, lvl});
      rreg(8'h30, {32'h0, d, 24'h0, c, 2'h0});
      rreg(8'h18, v);
    end
  endtask
  task automatic t_addr;
    rreg(8'h28, 64'h40_0000);
    go(exc_pkg::ACC_LOAD, exc_pkg::SZ_DWORD, exc_pkg::MODE_KERNEL, 64'h1004,
      1, 1, `EXC_BASE_BOOT + `EXC_VEC_COMMON, 5'h4);
    rreg(8'h38, BPC);
    // Handler software steps past the branch that held the return point
    wreg(8'h38, BPC + 64'h4);
    rreg(8'h38, BPC + 64'h4);
  endtask
  task automatic t_refill;
    wreg(8'h28, 64'h0);
    wreg(8'h20, 64'h5a);
    go(exc_pkg::ACC_STORE, exc_pkg::SZ_WORD, exc_pkg::MODE_USER, 64'h6000,
      0, 1, NB, 5'h3);
    rreg(8'h20, 64'h605a);
    rreg(8'h10, 64'h30);
    rreg(8'h40, 64'h30);
    chk("tag", 64'h5a, {56'h0, tag});
    go(exc_pkg::ACC_LOAD, exc_pkg::SZ_WORD, exc_pkg::MODE_USER, 64'he000,
      0, 1, CV, 5'h2);
    rreg(8'h38, 64'h6100);
    wreg(8'h28, 64'h20);
    go(exc_pkg::ACC_FETCH, exc_pkg::SZ_WORD, exc_pkg::MODE_USER,
      64'h1_0000_6000, 0, 1, NB + `EXC_VEC_WIDE, 5'h2);
  endtask
  task automatic t_kinds;
    go(exc_pkg::ACC_STORE, exc_pkg::SZ_HALF, exc_pkg::MODE_SUPER,
      64'hffff_ffff_8000_0000, 0, 1, CV, 5'h5);
    go(exc_pkg::ACC_LOAD, exc_pkg::SZ_BYTE, exc_pkg::MODE_USER,
      64'h4000_0000_0000_0000, 0, 1, CV, 5'h4);
    go(exc_pkg::ACC_STORE, exc_pkg::SZ_DWORD, exc_pkg::MODE_KERNEL, 64'h2000,
      0, 1, CV, 5'h1);
    go(exc_pkg::ACC_LOAD, exc_pkg::SZ_HALF, exc_pkg::MODE_KERNEL, 64'h4000,
      0, 1, CV, 5'h2);
    go(exc_pkg::ACC_LOAD, exc_pkg::SZ_HALF, exc_pkg::MODE_KERNEL, 64'h4001,
      0, 1, CV, 5'h4);
    go(exc_pkg::ACC_FETCH, exc_pkg::SZ_BYTE, exc_pkg::MODE_KERNEL, 64'h2,
      0, 1, CV, 5'h4);
    go(exc_pkg::ACC_LOAD, exc_pkg::SZ_WORD, exc_pkg::MODE_KERNEL, 64'h0,
      0, 0, 64'h0, 5'h0);
    // Unaligned ops exempt word and doubleword, never halfword
    @(posedge clk);
    uok <= 1'b1;
    go(exc_pkg::ACC_LOAD, exc_pkg::SZ_DWORD, exc_pkg::MODE_KERNEL, 64'h4,
      0, 0, 64'h0, 5'h0);
    go(exc_pkg::ACC_STORE, exc_pkg::SZ_WORD, exc_pkg::MODE_KERNEL, 64'h2,
      0, 0, 64'h0, 5'h0);
    go(exc_pkg::ACC_LOAD, exc_pkg::SZ_HALF, exc_pkg::MODE_KERNEL, 64'h1,
      0, 1, CV, 5'h4);
    @(posedge clk);
    {prb, va} <= {1'b1, 64'h2_2000};
    @(posedge clk);
    prb <= 1'b0;
    rreg(8'h00, 64'h11);
  endtask
  task automatic complete_run;
    if (fails == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #(40 * 2000);
    fails++;
    complete_run();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_addr();
    t_refill();
    t_kinds();
    complete_run();
  end
endmodule
`default_nettype wire
